// file: common/pio_pkg.sv
// package for the discrete request/state block: timing, register map, encodings, carriers
// assumes a single 100 MHz system clock
package pio_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DEB_TIME_US = 10000;
  localparam int unsigned DEB_CYC = DEB_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SOAK_TIME_MS = 1000;
  localparam int unsigned SOAK_CYC = SOAK_TIME_MS * (CLK_HZ / 1000);
  localparam int unsigned NZONE = 12;
  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [4:0] ADR_CTRL = 5'h00;
  localparam logic [4:0] ADR_STAT = 5'h04;
  localparam logic [4:0] ADR_ISTAT = 5'h08;
  localparam logic [4:0] ADR_IMASK = 5'h0c;
  localparam logic [4:0] ADR_SCH_HEAT = 5'h10;
  localparam logic [4:0] ADR_SCH_SETB = 5'h14;
  localparam int unsigned CB_HEAT = 0;
  localparam int unsigned CB_SETB = 1;
  localparam int unsigned CB_PUMP = 2;
  localparam int unsigned CB_AUTO = 3;
  localparam int unsigned CB_SCHED = 4;
  localparam int unsigned CB_TANDEM = 5;
  localparam int unsigned CTRL_W = 6;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam int unsigned SCH_OFF_POS = 16;
  localparam logic [10:0] SCH_RST = 11'h7ff;
  localparam int unsigned IB_READY_A = 0;
  localparam int unsigned IB_READY_B = 1;
  localparam int unsigned IB_ALARM = 2;
  localparam int unsigned IB_EMPTY = 3;
  localparam int unsigned IB_XOVER = 4;
  localparam int unsigned IB_REMOTE = 5;
  localparam int unsigned NIRQ = 6;
  localparam logic [5:0] IRQ_RST = 6'h00;
  // ----------------------------------------
  // contact encodings
  // ----------------------------------------
  localparam logic [1:0] RUN_OFF = 2'h0;
  localparam logic [1:0] RUN_HEAT = 2'h1;
  localparam logic [1:0] RUN_AT_TEMP = 2'h2;
  localparam logic [1:0] RUN_PUMP = 2'h3;
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_LOW = 2'h1;
  localparam logic [1:0] ERR_EMPTY = 2'h2;
  localparam logic [1:0] ERR_ALARM = 2'h3;
  typedef enum logic [1:0] {HS_OFF, HS_WARM, HS_SOAK, HS_READY} pio_heat_st_t;
  typedef struct packed {logic takeover; logic pump; logic setback; logic heat;} pio_req_t;
  // bit0 = output 1 (run low) .. bit3 = output 4 (error high)
  typedef struct packed {logic [1:0] err; logic [1:0] run;} pio_out_t;
  typedef struct packed {logic read; logic write; logic [4:0] address; logic [31:0] writedata;} pio_avs_req_t;
endpackage

// file: logic/pio_debounce.sv
// one-bit synchroniser and debouncer for a contact input
// assumes the input may change at any time relative to sys_clk_i
`timescale 1ns/1ps
`default_nettype none
module pio_debounce #(
  parameter int unsigned CYC = 16
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic raw_i,
  output logic level_o
);
  localparam int unsigned CW = $clog2(CYC + 1);
  if (CYC < 1) begin : g_chk
    $error("debounce count must be at least one");
  end
  logic s1_q, s2_q;
  logic [CW-1:0] cnt_q;
  wire logic differs = s2_q != level_o;
  wire logic done = cnt_q == CW'(CYC - 1);
  // ----------------------------------------
  // sync and hold-off
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= raw_i;
      s2_q <= s1_q;
    end
  end
  // a change must hold for CYC cycles; any bounce restarts the count
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= '0;
      level_o <= 1'b0;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (done) begin
      cnt_q <= '0;
      level_o <= s2_q;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end
endmodule
`default_nettype wire

// file: logic/pio_top.sv
// discrete controller interface: request inputs, run/error contacts, heat sequencing, registers
// assumes zone controllers report at-setpoint and in-window flags, an external minute-of-day count
//
// Functional notes
// - four request inputs: heat, setback, pump, controller takeover; each acted on.
// - requests are levels; heat and setback follow them, dropping ends them.
// - takeover only on unit A; it puts both units under controller command.
// - under controller command, display writes to heat, setback, pump are ignored.
// - under controller command automatic crossover is off; controller commands it.
// - each unit drives run low, run high, error low, error high contacts.
// - run code 00 off, 01 heating, 10 at temperature, 11 pumping.
// - error code 00 none, 01 drum low, 10 drum empty, 11 alarm.
// - contacts open at reset; an asserted bit closes its contact.
// - with autostart set, pump starts once all zones reach setpoint; here it waits for ready after soak, all zones in window, active unit.
// - schedule switches heat and setback on and off at set minutes.
// - pump air stays locked until all zones are inside their window.
// - warm-up while heating, soak after setpoint, then ready.
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module pio_top
  import pio_pkg::*;
#(
  parameter int unsigned NZ = NZONE,
  parameter int unsigned DEB_CYC_P = DEB_CYC,
  parameter int unsigned SOAK_CYC_P = SOAK_CYC
) (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire pio_pkg::pio_avs_req_t avs_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic irq_o,
  input wire pio_pkg::pio_req_t req_i,
  input wire logic [1:0][NZ-1:0] zone_at_sp_i,
  input wire logic [1:0][NZ-1:0] zone_in_win_i,
  input wire logic [1:0] drum_low_i,
  input wire logic [1:0] drum_empty_i,
  input wire logic alarm_i,
  input wire logic [10:0] tod_min_i,
  output wire pio_pkg::pio_out_t [1:0] contact_o,
  output wire logic [1:0] heat_en_o,
  output wire logic [1:0] setback_o,
  output wire logic [1:0] pump_o,
  output wire logic [1:0] air_en_o,
  output logic active_unit_o
);
  import pio_pkg::*;
  localparam int unsigned SW = $clog2(SOAK_CYC_P + 1);
  if (NZ < 1 || NZ > NZONE || SOAK_CYC_P < 1) begin : g_chk
    $error("zone count or soak count out of range");
  end

  // ----------------------------------------
  // request inputs
  // ----------------------------------------
  pio_req_t req_q;
  logic pump_req_prev_q;
  for (genvar i = 0; i < 4; i++) begin : g_deb
    pio_debounce #(.CYC(DEB_CYC_P)) u_deb (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .raw_i(req_i[i]),
      .level_o(req_q[i])
    );
  end
  // takeover exists on unit A only and covers both units
  wire logic remote = req_q.takeover;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic wait_q;
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [NIRQ-1:0] istat_q, imask_q, ev;
  logic [10:0] sh_on_q, sh_off_q, ss_on_q, ss_off_q, tod_q;
  logic [1:0] ready;
  logic [1:0] all_win;
  wire logic req = avs_i.read | avs_i.write;
  // one wait cycle, then the answer cycle in which writes land
  wire logic wr = avs_i.write & ~wait_q;
  wire logic sel_ctrl = avs_i.address == ADR_CTRL;
  wire logic sel_stat = avs_i.address == ADR_STAT;
  wire logic sel_istat = avs_i.address == ADR_ISTAT;
  wire logic sel_imask = avs_i.address == ADR_IMASK;
  wire logic sel_sh = avs_i.address == ADR_SCH_HEAT;
  wire logic sel_ss = avs_i.address == ADR_SCH_SETB;
  wire logic [31:0] stat_w = {16'h0000, air_en_o, active_unit_o, remote, req_q, contact_o};
  wire logic [31:0] rd_mux =
    sel_ctrl ? 32'(ctrl_q) :
    sel_stat ? stat_w :
    sel_istat ? 32'(istat_q) :
    sel_imask ? 32'(imask_q) :
    sel_sh ? {5'h00, sh_off_q, 5'h00, sh_on_q} :
    sel_ss ? {5'h00, ss_off_q, 5'h00, ss_on_q} : 32'h0000_0000;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_q <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      wait_q <= ~(req & wait_q);
      if (req & wait_q) avs_readdata_o <= rd_mux;
    end
  end
  assign avs_waitrequest_o = wait_q;

  // ----------------------------------------
  // schedule and control register
  // ----------------------------------------
  wire logic tick = (tod_min_i != tod_q) & ctrl_q[CB_SCHED] & ~remote;
  wire logic [CTRL_W-1:0] wmask = remote ? 6'h38 : 6'h3f;
  always_comb begin
    ctrl_d = ctrl_q;
    if (wr && sel_ctrl) ctrl_d = (ctrl_q & ~wmask) | (avs_i.writedata[CTRL_W-1:0] & wmask);
    if (tick && tod_min_i == sh_on_q) ctrl_d[CB_HEAT] = 1'b1;
    if (tick && tod_min_i == sh_off_q) ctrl_d[CB_HEAT] = 1'b0;
    if (tick && tod_min_i == ss_on_q) ctrl_d[CB_SETB] = 1'b1;
    if (tick && tod_min_i == ss_off_q) ctrl_d[CB_SETB] = 1'b0;
  end
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q <= CTRL_RST;
      tod_q <= 11'h000;
      {sh_on_q, sh_off_q, ss_on_q, ss_off_q} <= {4{SCH_RST}};
    end else begin
      ctrl_q <= ctrl_d;
      tod_q <= tod_min_i;
      if (wr && sel_sh) {sh_off_q, sh_on_q} <= {avs_i.writedata[26:16], avs_i.writedata[10:0]};
      if (wr && sel_ss) {ss_off_q, ss_on_q} <= {avs_i.writedata[26:16], avs_i.writedata[10:0]};
    end
  end
  // requests are levels: the command follows them directly
  wire logic heat_cmd = remote ? req_q.heat : ctrl_q[CB_HEAT];
  wire logic setb_cmd = remote ? req_q.setback : ctrl_q[CB_SETB];
  wire logic pump_cmd = remote ? req_q.pump : ctrl_q[CB_PUMP];

  // ----------------------------------------
  // crossover between units
  // ----------------------------------------
  wire logic other = ~active_unit_o;
  wire logic tandem = ctrl_q[CB_TANDEM];
  wire logic empty_act = drum_empty_i[active_unit_o];
  // locally the unit swaps itself; under takeover only a fresh pump request swaps
  wire logic xo_auto = ~remote & tandem & empty_act & ready[other];
  wire logic xo_plc = remote & tandem & empty_act & req_q.pump & ~pump_req_prev_q;
  wire logic xover = xo_auto | xo_plc;
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active_unit_o <= 1'b0;
      pump_req_prev_q <= 1'b0;
    end else begin
      pump_req_prev_q <= req_q.pump;
      if (xover) active_unit_o <= other;
    end
  end

  // ----------------------------------------
  // per-unit heat sequence and contacts
  // ----------------------------------------
  wire logic [1:0] err_code = alarm_i ? ERR_ALARM :
    empty_act ? ERR_EMPTY :
    drum_low_i[active_unit_o] ? ERR_LOW : ERR_NONE;
  for (genvar u = 0; u < 2; u++) begin : g_unit
    pio_heat_st_t st_q;
    logic [SW-1:0] soak_q;
    logic heat_q, setb_q, pump_q, air_q;
    pio_out_t out_q;
    wire logic on = heat_cmd & (u == 0 || tandem);
    wire logic all_sp = &zone_at_sp_i[u];
    wire logic soak_done = soak_q == SW'(SOAK_CYC_P - 1);
    wire logic pump_d = on & ready[u] & all_win[u] & (active_unit_o == 1'(u)) &
      (pump_cmd | ctrl_q[CB_AUTO]);
    assign all_win[u] = &zone_in_win_i[u];
    assign ready[u] = st_q == HS_READY;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        st_q <= HS_OFF;
        soak_q <= '0;
      end else begin
        // count holds at its end so a late window still lets the unit go ready
        soak_q <= (st_q != HS_SOAK) ? '0 : soak_done ? soak_q : soak_q + SW'(1);
        case (st_q)
          HS_OFF: if (on) st_q <= HS_WARM;
          HS_WARM: if (!on) st_q <= HS_OFF; else if (all_sp) st_q <= HS_SOAK;
          HS_SOAK: if (!on) st_q <= HS_OFF; else if (!all_sp) st_q <= HS_WARM; else if (soak_done && all_win[u]) st_q <= HS_READY;
          HS_READY: if (!on) st_q <= HS_OFF; else if (!all_win[u]) st_q <= HS_WARM;
          default: st_q <= HS_OFF;
        endcase
      end
    end
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        {heat_q, setb_q, pump_q, air_q} <= 4'h0;
        out_q <= '0;
      end else begin
        heat_q <= on;
        setb_q <= on & setb_cmd;
        air_q <= ready[u] & all_win[u];
        pump_q <= pump_d;
        out_q.err <= err_code;
        out_q.run <= !on ? RUN_OFF : pump_d ? RUN_PUMP : ready[u] ? RUN_AT_TEMP : RUN_HEAT;
      end
    end
    assign contact_o[u] = out_q;
    assign heat_en_o[u] = heat_q;
    assign setback_o[u] = setb_q;
    assign pump_o[u] = pump_q;
    assign air_en_o[u] = air_q;
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  logic [1:0] ready_prev_q;
  logic alarm_prev_q, empty_prev_q, remote_prev_q;
  always_comb begin
    ev = '0;
    ev[IB_READY_A] = ready[0] & ~ready_prev_q[0];
    ev[IB_READY_B] = ready[1] & ~ready_prev_q[1];
    ev[IB_ALARM] = alarm_i & ~alarm_prev_q;
    ev[IB_EMPTY] = empty_act & ~empty_prev_q;
    ev[IB_XOVER] = xover;
    ev[IB_REMOTE] = remote ^ remote_prev_q;
  end
  // a new event in the clearing cycle survives the clear
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      istat_q <= IRQ_RST;
      imask_q <= IRQ_RST;
      irq_o <= 1'b0;
      {ready_prev_q, alarm_prev_q, empty_prev_q, remote_prev_q} <= 5'h00;
    end else begin
      istat_q <= (istat_q & ~((wr & sel_istat) ? avs_i.writedata[NIRQ-1:0] : '0)) | ev;
      if (wr && sel_imask) imask_q <= avs_i.writedata[NIRQ-1:0];
      irq_o <= |(istat_q & imask_q);
      {ready_prev_q, alarm_prev_q, empty_prev_q, remote_prev_q} <= {ready, alarm_i, empty_act, remote};
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  pio_heat_st_t st_q_a;
  assign st_q_a = g_unit[0].st_q;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  a_takeover_locks: assert property (remote && wr && sel_ctrl |=> ctrl_q[2:0] == $past(ctrl_q[2:0]))
    else $error("display write changed a locked control bit");
  a_heat_follows: assert property (##1 heat_en_o[0] == $past(heat_cmd))
    else $error("unit A heater does not follow its command");
  a_run_off: assert property (!heat_en_o[0] |-> contact_o[0].run == RUN_OFF)
    else $error("run code not off while heat off");
  a_pump_code: assert property (pump_o[0] |-> contact_o[0].run == RUN_PUMP)
    else $error("pump running without pump run code");
  a_alarm_code: assert property (alarm_i |=> contact_o[0].err == ERR_ALARM && contact_o[1].err == ERR_ALARM)
    else $error("alarm not shown on error contacts");
  a_air_lock: assert property (air_en_o[0] |-> $past(all_win[0]) && $past(ready[0]))
    else $error("air released outside window");
  a_no_auto_xover: assert property (remote && !req_q.pump |=> active_unit_o == $past(active_unit_o))
    else $error("crossover under controller command without request");
  a_soak_then_ready: assert property ($rose(ready[0]) |-> $past(st_q_a) == HS_SOAK)
    else $error("ready reached without soak");
  a_autostart: assert property (heat_cmd && ready[0] && all_win[0] && !active_unit_o && ctrl_q[CB_AUTO] |=> pump_o[0])
    else $error("autostart did not start the pump");
  a_sched_on: assert property (tick && tod_min_i == sh_on_q && tod_min_i != sh_off_q |=> ctrl_q[CB_HEAT])
    else $error("schedule did not switch heat on");
  c_ready: cover property ($rose(ready[0]));
  c_xover: cover property (xover);
  c_takeover: cover property ($rose(remote));
  c_irq: cover property ($rose(irq_o));
endmodule
`default_nettype wire

// file: testbench/pio_plc_model.sv
// far-side controller model: drives the four request contacts, with optional chatter
// assumes the bench supplies the wanted request levels on cmd_i
`timescale 1ns/1ps
`default_nettype none
module pio_plc_model (
  input wire logic sys_clk_i,
  input wire pio_pkg::pio_req_t cmd_i,
  input wire logic bounce_i,
  input wire pio_pkg::pio_out_t state_i,
  output var pio_pkg::pio_req_t req_o
);
  import pio_pkg::*;
  logic ready;
  logic [3:0] want;
  logic [3:0] chg_q = 4'h0;
  logic [3:0] last_q = 4'h0;
  logic [1:0] cnt_q = 2'h0;
  // pump asked for only once the unit reports ready
  assign ready = (state_i.run == RUN_AT_TEMP) || (state_i.run == RUN_PUMP);
  assign want = {cmd_i.takeover, cmd_i.pump & ready, cmd_i.setback, cmd_i.heat};
  always @(posedge sys_clk_i) begin
    last_q <= want;
    if (want != last_q) begin
      chg_q <= want ^ last_q;
      cnt_q <= bounce_i ? 2'h3 : 2'h0;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
    // changed bits chatter on odd counts, like a real relay contact
    req_o <= want ^ (cnt_q[0] ? chg_q : 4'h0);
  end
endmodule
`default_nettype wire

// file: testbench/pio_top_tb.sv
// self-checking bench for the discrete request/state block
// assumes short debounce and soak counts; controller model on the request side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin errors++; $display("BAD %s exp %h got %h", nm, ex, got); end end
module pio_top_tb;
  import pio_pkg::*;
  localparam int DEB = 4;
  localparam int SOAK = 8;
  // zone configuration the zone flags stand for
  localparam int SP_F = 350;
  localparam int SB_F = 320;
  localparam logic [11:0] HOSE_Z = 12'h005;
  if (SP_F - SB_F < 20) begin : g_sb
    $error("setback not far enough below setpoint");
  end
  if ((HOSE_Z & ~12'h555) != 12'h000) begin : g_hose
    $error("hose zone type on an even zone");
  end
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int mheat = 0;
  int mready = 0;
  int mpump = 0;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  pio_avs_req_t avs = '0;
  logic [31:0] rdata, q;
  logic waitreq, irq, active, bounce = 1'b0;
  pio_req_t cmd = '0;
  pio_req_t req;
  logic [1:0][11:0] zsp = '0;
  logic [1:0][11:0] zwin = '0;
  logic [1:0] dlow = 2'h0;
  logic [1:0] demp = 2'h0;
  logic alarm = 1'b0;
  logic [10:0] tod = 11'h000;
  pio_out_t [1:0] contact;
  logic [1:0] heat_en, setback, pump, air;
  always #5 sys_clk_i = ~sys_clk_i;
  pio_top #(.NZ(12), .DEB_CYC_P(DEB), .SOAK_CYC_P(SOAK)) DUT (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .avs_i(avs), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .irq_o(irq), .req_i(req),
    .zone_at_sp_i(zsp), .zone_in_win_i(zwin), .drum_low_i(dlow), .drum_empty_i(demp), .alarm_i(alarm),
    .tod_min_i(tod), .contact_o(contact), .heat_en_o(heat_en), .setback_o(setback), .pump_o(pump),
    .air_en_o(air), .active_unit_o(active));
  pio_plc_model plc (.sys_clk_i(sys_clk_i), .cmd_i(cmd), .bounce_i(bounce), .state_i(contact[0]), .req_o(req));
  // ----------------------------------------
  // model and helpers
  // ----------------------------------------
  function automatic logic [1:0] run_code(int h, int r, int p);
    return (h == 0) ? 2'h0 : (r == 0) ? 2'h1 : (p == 0) ? 2'h2 : 2'h3;
  endfunction
  function automatic logic [1:0] err_code(int lo, int em, int al);
    return al ? 2'h3 : em ? 2'h2 : lo ? 2'h1 : 2'h0;
  endfunction
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      complete_run();
    end
  end
  task automatic wt(int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    avs <= '{read: !wr, write: wr, address: a, writedata: d};
    do @(posedge sys_clk_i); while (waitreq !== 1'b0);
    q = rdata;
    avs <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~d};
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] m, input logic [31:0] ex);
    bus(1'b0, a, 32'h0);
    `CHK("reg", ex, q & m)
  endtask
  task automatic wait_run(int u);
    logic [1:0] ex;
    ex = run_code(mheat, mready, mpump);
    for (int i = 0; i < 60 && contact[u].run !== ex; i++) @(posedge sys_clk_i);
    `CHK("run", ex, contact[u].run)
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    void'($urandom(56));
    `CHK("contacts", 8'h00, contact)
    `CHK("wait", 1'b1, waitreq)
    rdc(ADR_CTRL, 32'hffffffff, 32'h0);
    rdc(ADR_IMASK, 32'hffffffff, 32'h0);
    rdc(ADR_SCH_HEAT, 32'h7ff, 32'h7ff);
    rdc(5'h18, 32'hffffffff, 32'h0);
    bus(1'b1, ADR_CTRL, 32'h20);
    cmd.takeover <= 1'b1;
    wt(DEB + 8);
    rdc(ADR_STAT, 32'h1000, 32'h1000);
    bounce <= 1'b1;
    cmd.heat <= 1'b1;
    wt(2);
    cmd.heat <= 1'b0;
    wt(DEB + 8);
    `CHK("chatter", 1'b0, heat_en[0])
    cmd.heat <= 1'b1;
    mheat = 1;
    wait_run(0);
    wait_run(1);
    zsp <= '1;
    zwin <= '1;
    wt(SOAK / 2);
    `CHK("soak", RUN_HEAT, contact[0].run)
    mready = 1;
    wait_run(0);
    `CHK("air", 1'b1, air[0])
    rdc(ADR_ISTAT, 32'h1, 32'h1);
    bus(1'b1, ADR_IMASK, 32'h1);
    wt(3);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, ADR_ISTAT, 32'h1);
    wt(3);
    `CHK("irq", 1'b0, irq)
    cmd.pump <= 1'b1;
    mpump = 1;
    wait_run(0);
    `CHK("pump", 1'b1, pump[0])
    cmd.pump <= 1'b0;
    mpump = 0;
    wait_run(0);
    bus(1'b1, ADR_CTRL, 32'h28);
    mpump = 1;
    wait_run(0);
    bus(1'b1, ADR_CTRL, 32'h20);
    mpump = 0;
    wait_run(0);
    zwin[0][3] <= 1'b0;
    mready = 0;
    wait_run(0);
    `CHK("air", 1'b0, air[0])
    zwin <= '1;
    mready = 1;
    wait_run(0);
    bounce <= 1'b0;
    bus(1'b1, ADR_CTRL, 32'h22);
    wt(4);
    `CHK("setback", 2'h0, setback)
    rdc(ADR_CTRL, 32'h3f, 32'h20);
    repeat (8) begin
      q = $urandom;
      dlow <= {2{q[0]}};
      demp <= {2{q[1]}};
      alarm <= q[2];
      tod <= q[18:8];
      wt(4);
      `CHK("err a", err_code(q[0], q[1], q[2]), contact[0].err)
      `CHK("err b", err_code(q[0], q[1], q[2]), contact[1].err)
      `CHK("active", 1'b0, active)
    end
    dlow <= 2'h0;
    demp <= 2'h1;
    alarm <= 1'b0;
    cmd.pump <= 1'b1;
    wt(DEB + 8);
    `CHK("xover", 1'b1, active)
    cmd.pump <= 1'b0;
    demp <= 2'h0;
    cmd.setback <= 1'b1;
    wt(DEB + 8);
    `CHK("setback", 2'h3, setback)
    cmd.setback <= 1'b0;
    wt(DEB + 8);
    `CHK("setback", 2'h0, setback)
    cmd.takeover <= 1'b0;
    wt(DEB + 8);
    bus(1'b1, ADR_CTRL, 32'h31);
    bus(1'b1, ADR_SCH_SETB, 32'h07ff0005);
    tod <= 11'h004;
    wt(3);
    tod <= 11'h005;
    wt(4);
    `CHK("sched on", 1'b1, setback[0])
    bus(1'b1, ADR_SCH_SETB, 32'h00060005);
    tod <= 11'h006;
    wt(4);
    `CHK("sched off", 1'b0, setback[0])
    cmd.heat <= 1'b0;
    bus(1'b1, ADR_CTRL, 32'h30);
    mheat = 0;
    wait_run(0);
    complete_run();
  end
endmodule
`default_nettype wire
